/* File: trx_dev.sv */
//Contract
// - Capability bit 0 shows low-power start-up support
// - Low-power start-up runs management only
// - Host holds transmit gate low until checked
// - Rising transmit gate leaves low power
// - Clear reset bit after start-up init
// - Reset by pin or device 1 bit
// - Reset runs init, then clears bit
// - Pin low sets device 1 reset bit
// - Pin and bit combinations select state
// - Optical output off within 100us
// - Normal operation within 5 s
// - Clause 45 management sampled on MDC
// - Port address from five input pins
// - Supply references held in info store
// - References scaled 1A, 2A, 2A plus voltage
// - Host holds reset low 1 ms minimum
// - Gate low forces transmitter off
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module trx_dev #(
    parameter bit LOWPWR_SUPPORT = 1'b1,
    parameter int INIT_CYCLES = trx_pkg::INIT_CYC,
    parameter logic [15:0] REF_5V_PCT = 16'h0032,
    parameter logic [15:0] REF_33V_PCT = 16'h0032,
    parameter logic [15:0] REF_ADAPT_PCT = 16'h0032,
    parameter logic [15:0] ADAPT_NOM_MV = 16'h04B0
) (
    // Link to the host
    trx_link_if.dev link,
    // Core clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // Module status
    output logic laser_on_out,
    output logic datapath_en_out,
    output logic low_power_out,
    output logic reset_bit_out
);
    import trx_pkg::*;

    localparam int ICW = $clog2(INIT_CYCLES + 1);

    logic [2:0] core_s;
    logic pin_ok;
    logic gate_on;
    logic tgl_s;
    logic tgl_d_r;
    logic mreset_evt;
    dev_state_t state_r;
    logic [1:0] settle_r;
    logic [ICW-1:0] init_cnt_r;
    logic init_done;
    logic rst_bit_r;
    logic present_n_r;

    logic [4:0] portaddr_s;
    logic rst_bit_m;
    logic [5:0] pre_cnt_r;
    logic in_frame_r;
    logic [4:0] bit_cnt_r;
    logic [14:0] sh_r;
    logic [13:0] hdr;
    logic [15:0] wdata;
    logic hdr_pcs;
    mdio_op_t op_r;
    logic dsel_r;
    logic hit_r;
    logic [15:0] addr_r [2];
    logic [15:0] addr_cur;
    logic [15:0] rd_word;
    logic [15:0] tx_sh_r;
    logic mdio_out_r;
    logic mdio_oe_n_r;
    logic rst_tgl_r;

    // Pins and the management reset request into the core domain
    trx_sync #(.W(3)) u_core_sync (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .d_in({link.rstpin, link.txgate, rst_tgl_r}),
        .q_out(core_s)
    );
    assign pin_ok = core_s[2];
    assign gate_on = core_s[1];
    assign tgl_s = core_s[0];
    assign mreset_evt = tgl_s ^ tgl_d_r;
    assign init_done = (state_r == ST_INIT) && pin_ok && !mreset_evt
        && (init_cnt_r == ICW'(INIT_CYCLES - 1));

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tgl_d_r <= 1'b0;
            present_n_r <= 1'b0;
        end else begin
            tgl_d_r <= tgl_s;
            present_n_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            settle_r <= 2'h0;
        end else if (state_r == ST_PWRUP && settle_r != 2'(SETTLE_CYC - 1)) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= ST_PWRUP;
        end else begin
            case (state_r)
                ST_PWRUP: begin
                    if (settle_r == 2'(SETTLE_CYC - 1)) begin
                        if (!pin_ok) begin
                            state_r <= ST_PINRST;
                        end else if (LOWPWR_SUPPORT && !gate_on) begin
                            state_r <= ST_LOWPWR;
                        end else begin
                            state_r <= ST_INIT;
                        end
                    end
                end
                ST_LOWPWR: begin
                    if (!pin_ok) begin
                        state_r <= ST_PINRST;
                    end else if (gate_on) begin
                        state_r <= ST_INIT;
                    end
                end
                ST_INIT: begin
                    if (!pin_ok) begin
                        state_r <= ST_PINRST;
                    end else if (init_done) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!pin_ok) begin
                        state_r <= ST_PINRST;
                    end else if (mreset_evt) begin
                        state_r <= ST_INIT;
                    end
                end
                ST_PINRST: begin
                    if (pin_ok) begin
                        // Back to low power if the gate is still held low
                        if (LOWPWR_SUPPORT && !gate_on) begin
                            state_r <= ST_LOWPWR;
                        end else begin
                            state_r <= ST_INIT;
                        end
                    end
                end
                default: begin
                    state_r <= ST_PWRUP;
                end
            endcase
        end
    end

    // Init restarts on a fresh management reset
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            init_cnt_r <= '0;
        end else if (state_r != ST_INIT || mreset_evt) begin
            init_cnt_r <= '0;
        end else if (!init_done) begin
            init_cnt_r <= init_cnt_r + ICW'(1);
        end
    end

    // Set wins over clear
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_bit_r <= 1'b1;
        end else if (!pin_ok || mreset_evt) begin
            rst_bit_r <= 1'b1;
        end else if (init_done) begin
            rst_bit_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            laser_on_out <= 1'b0;
            datapath_en_out <= 1'b0;
            low_power_out <= 1'b0;
            reset_bit_out <= 1'b1;
        end else begin
            laser_on_out <= gate_on && (state_r == ST_RUN);
            datapath_en_out <= (state_r == ST_RUN) && pin_ok && !mreset_evt;
            low_power_out <= (state_r == ST_LOWPWR);
            reset_bit_out <= rst_bit_r || !pin_ok || mreset_evt;
        end
    end

    // Management side, clocked by MDC
    trx_sync #(.W(6)) u_mdc_sync (
        .clk_in(link.mdc),
        .resetn_in(resetn_in),
        .d_in({link.port_address_inputs, rst_bit_r}),
        .q_out({portaddr_s, rst_bit_m})
    );

    assign hdr = {sh_r[12:0], link.mdio};
    assign wdata = {sh_r, link.mdio};
    assign hdr_pcs = (hdr[4:0] == DEV_PCS);
    assign addr_cur = addr_r[hdr_pcs];

    always_comb begin
        rd_word = 16'h0000;
        if (addr_cur == CTRL_ADDR) begin
            rd_word[RESET_BIT] = rst_bit_m;
        end else if (!hdr_pcs) begin
            case (addr_cur)
                OPT_CAP_ADDR: rd_word[LOWPWR_CAP_BIT] = LOWPWR_SUPPORT;
                INFO_BASE_ADDR: rd_word = REF_5V_PCT;
                INFO_BASE_ADDR + 16'h0001: rd_word = REF_33V_PCT;
                INFO_BASE_ADDR + 16'h0002: rd_word = REF_ADAPT_PCT;
                INFO_BASE_ADDR + 16'h0003: rd_word = ADAPT_NOM_MV;
                default: rd_word = 16'h0000;
            endcase
        end
    end

    // Preamble of ones, then a start pair of zeros
    always_ff @(posedge link.mdc or negedge resetn_in) begin
        if (!resetn_in) begin
            pre_cnt_r <= 6'h00;
            in_frame_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            sh_r <= 15'h0000;
        end else begin
            sh_r <= {sh_r[13:0], link.mdio};
            if (!in_frame_r) begin
                if (link.mdio) begin
                    if (pre_cnt_r != 6'(PREAMBLE_BITS)) begin
                        pre_cnt_r <= pre_cnt_r + 6'h01;
                    end
                end else if (pre_cnt_r == 6'(PREAMBLE_BITS)) begin
                    in_frame_r <= 1'b1;
                    bit_cnt_r <= 5'h01;
                end else begin
                    pre_cnt_r <= 6'h00;
                end
            end else begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
                if (bit_cnt_r == 5'(DATA_LAST)) begin
                    in_frame_r <= 1'b0;
                    pre_cnt_r <= 6'h00;
                end
            end
        end
    end

    always_ff @(posedge link.mdc or negedge resetn_in) begin
        if (!resetn_in) begin
            op_r <= OP_ADDR;
            dsel_r <= 1'b0;
            hit_r <= 1'b0;
            tx_sh_r <= 16'h0000;
        end else if (in_frame_r && bit_cnt_r == 5'(HDR_LAST)) begin
            op_r <= mdio_op_t'(hdr[11:10]);
            dsel_r <= hdr_pcs;
            hit_r <= (hdr[13:12] == 2'b00) && (hdr[9:5] == portaddr_s)
                && (hdr[4:0] == DEV_PMA || hdr_pcs);
            tx_sh_r <= rd_word;
        end else if (in_frame_r && bit_cnt_r > 5'(TA_BIT)) begin
            tx_sh_r <= {tx_sh_r[14:0], 1'b0};
        end
    end

    // Drive turnaround zero and read data after each rising MDC edge
    always_ff @(posedge link.mdc or negedge resetn_in) begin
        if (!resetn_in) begin
            mdio_out_r <= 1'b1;
            mdio_oe_n_r <= 1'b1;
        end else if (in_frame_r && hit_r && op_r[1] && bit_cnt_r >= 5'(TA_BIT)
                     && bit_cnt_r != 5'(DATA_LAST)) begin
            mdio_oe_n_r <= 1'b0;
            mdio_out_r <= (bit_cnt_r == 5'(TA_BIT)) ? 1'b0 : tx_sh_r[15];
        end else begin
            mdio_oe_n_r <= 1'b1;
            mdio_out_r <= 1'b1;
        end
    end

    always_ff @(posedge link.mdc or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_r[0] <= 16'h0000;
            addr_r[1] <= 16'h0000;
            rst_tgl_r <= 1'b0;
        end else if (in_frame_r && hit_r && bit_cnt_r == 5'(DATA_LAST)) begin
            case (op_r)
                OP_ADDR: addr_r[dsel_r] <= wdata;
                OP_RINC: addr_r[dsel_r] <= addr_r[dsel_r] + 16'h0001;
                OP_WRITE: begin
                    if (!dsel_r && addr_r[0] == CTRL_ADDR && wdata[RESET_BIT]) begin
                        rst_tgl_r <= ~rst_tgl_r;
                    end
                end
                default: addr_r[dsel_r] <= addr_r[dsel_r];
            endcase
        end
    end

    assign link.mdio_d_out = mdio_out_r;
    assign link.mdio_d_oe_n = mdio_oe_n_r;
    assign link.present_n = present_n_r;
endmodule

/* File: trx_pkg.sv */
package trx_pkg;
    // Core clock
    localparam int CLK_MHZ = 25;
    // Start-up and reset timing
    localparam int T_INIT_MAX_S = 5;
    localparam int T_INIT_US = 10000;
    localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
    localparam int T_TXOFF_US = 100;
    localparam int TXOFF_MAX_CYC = T_TXOFF_US * CLK_MHZ;
    localparam int T_RST_MIN_MS = 1;
    localparam int RST_MIN_CYC = T_RST_MIN_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC = 3;
    localparam int LOWPWR_TYP_MW = 1000;
    // Full scale of stored supply references, 100 percent
    localparam int REF_5V_FULL_MA = 1000;
    localparam int REF_33V_FULL_MA = 2000;
    localparam int REF_ADAPT_FULL_MA = 2000;
    // Management frame, device side counts from the first start bit
    localparam int MDC_HALF_CYC = 5;
    localparam int PREAMBLE_BITS = 32;
    localparam int HDR_LAST = 13;
    localparam int TA_BIT = 14;
    localparam int DATA_LAST = 31;
    localparam int HOST_TA_IDX = 46;
    localparam int HOST_DATA_IDX = 48;
    localparam int FRAME_LAST = 63;
    localparam logic [4:0] DEV_PMA = 5'h01;
    localparam logic [4:0] DEV_PCS = 5'h03;
    localparam logic [15:0] CTRL_ADDR = 16'h0000;
    localparam logic [15:0] OPT_CAP_ADDR = 16'h8005;
    localparam logic [15:0] INFO_BASE_ADDR = 16'h8007;
    localparam int RESET_BIT = 15;
    localparam int LOWPWR_CAP_BIT = 0;
    typedef enum logic [1:0] {
        OP_ADDR = 2'b00,
        OP_WRITE = 2'b01,
        OP_RINC = 2'b10,
        OP_READ = 2'b11
    } mdio_op_t;
    // Host register map
    localparam logic [7:0] HCTRL_OFS = 8'h00;
    localparam logic [7:0] HCMD_OFS = 8'h04;
    localparam logic [7:0] HDATA_OFS = 8'h08;
    localparam logic [7:0] HSTAT_OFS = 8'h0C;
    localparam logic [31:0] HCTRL_RST = 32'h0000_0000;
    localparam int CTRL_TXGATE_BIT = 0;
    localparam int CTRL_RST_BIT = 1;
    localparam int CTRL_PORTADDR_LSB = 4;
    localparam int CMD_DEV_LSB = 2;
    localparam int CMD_GO_BIT = 31;
    localparam int STAT_PRES_BIT = 1;
    localparam int STAT_RD_LSB = 16;
    typedef enum logic [2:0] {
        ST_PWRUP = 3'b000,
        ST_INIT = 3'b001,
        ST_RUN = 3'b011,
        ST_PINRST = 3'b010,
        ST_LOWPWR = 3'b100
    } dev_state_t;
endpackage

/* File: trx_link_if.sv */
`timescale 1ns/1ps
interface trx_link_if;
    logic mdc;
    logic mdio_h_out;
    logic mdio_h_oe_n;
    logic mdio_d_out;
    logic mdio_d_oe_n;
    logic mdio;
    logic txgate_oe_n;
    logic txgate;
    logic rstpin_oe_n;
    logic rstpin;
    logic [4:0] port_address_inputs;
    logic present_n;

    // Open-drain lines with pull-ups
    assign mdio = (mdio_h_oe_n | mdio_h_out) & (mdio_d_oe_n | mdio_d_out);
    assign txgate = txgate_oe_n;
    assign rstpin = rstpin_oe_n;

    modport host (
        output mdc, mdio_h_out, mdio_h_oe_n, txgate_oe_n, rstpin_oe_n, port_address_inputs,
        input mdio, present_n
    );
    modport dev (
        input mdc, mdio, txgate, rstpin, port_address_inputs,
        output mdio_d_out, mdio_d_oe_n, present_n
    );
endinterface

/* File: trx_sync.sv */
`timescale 1ns/1ps
module trx_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // Data
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

/* File: trx_host.sv */
`timescale 1ns/1ps
module trx_host #(
    parameter int RST_MIN_CYCLES = trx_pkg::RST_MIN_CYC,
    parameter int MDC_HALF = trx_pkg::MDC_HALF_CYC
) (
    // Link to the module
    trx_link_if.host link,
    // Clock and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    // APB slave
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);
    import trx_pkg::*;

    localparam int RCW = $clog2(RST_MIN_CYCLES + 1);
    localparam int DVW = $clog2(MDC_HALF + 1);

    logic [1:0] in_s;
    logic acc;
    logic wr;
    logic map_ok;
    logic [31:0] ctrl_r;
    logic [15:0] data_r;
    logic [RCW-1:0] rst_cnt_r;
    logic rst_oe_n_r;
    logic gate_oe_n_r;
    logic [DVW-1:0] div_r;
    logic mdc_r;
    logic wrap;
    logic fall;
    logic rise;
    logic go;
    logic busy_r;
    logic launched_r;
    logic rd_op_r;
    logic [5:0] idx_r;
    logic [63:0] sh_r;
    logic [15:0] rd_r;
    logic mdio_out_r;
    logic mdio_oe_n_r;

    trx_sync #(.W(2)) u_sync (
        .clk_in(mclk_in),
        .resetn_in(resetn_in),
        .d_in({link.mdio, link.present_n}),
        .q_out(in_s)
    );

    assign acc = psel_in && penable_in && pready_out;
    assign wr = acc && pwrite_in;
    assign map_ok = (paddr_in == HCTRL_OFS) || (paddr_in == HCMD_OFS)
        || (paddr_in == HDATA_OFS) || (paddr_in == HSTAT_OFS);
    assign go = wr && paddr_in == HCMD_OFS && pwdata_in[CMD_GO_BIT] && !busy_r;

    // One wait state on every access
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !map_ok;
            if (psel_in && penable_in && !pready_out) begin
                case (paddr_in)
                    HCTRL_OFS: prdata_out <= ctrl_r;
                    HDATA_OFS: prdata_out <= {16'h0000, data_r};
                    HSTAT_OFS: prdata_out <= {rd_r, 14'h0000, !in_s[0], busy_r};
                    default: prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r <= HCTRL_RST;
            data_r <= 16'h0000;
        end else if (wr) begin
            if (paddr_in == HCTRL_OFS) begin
                ctrl_r <= {23'h000000, pwdata_in[8:4], 2'b00, pwdata_in[1:0]};
            end
            if (paddr_in == HDATA_OFS) begin
                data_r <= pwdata_in[15:0];
            end
        end
    end

    // Reset pin low while asked and for the minimum width
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_cnt_r <= '0;
        end else if (wr && paddr_in == HCTRL_OFS && pwdata_in[CTRL_RST_BIT]) begin
            rst_cnt_r <= RCW'(RST_MIN_CYCLES);
        end else if (rst_cnt_r != '0) begin
            rst_cnt_r <= rst_cnt_r - RCW'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_oe_n_r <= 1'b1;
            gate_oe_n_r <= 1'b0;
        end else begin
            rst_oe_n_r <= !(ctrl_r[CTRL_RST_BIT] || rst_cnt_r != '0);
            gate_oe_n_r <= ctrl_r[CTRL_TXGATE_BIT];
        end
    end

    assign wrap = (div_r == DVW'(MDC_HALF - 1));
    assign fall = wrap && mdc_r;
    assign rise = wrap && !mdc_r;

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_r <= '0;
            mdc_r <= 1'b0;
        end else if (wrap) begin
            div_r <= '0;
            mdc_r <= !mdc_r;
        end else begin
            div_r <= div_r + DVW'(1);
        end
    end

    // Data changes on MDC fall, read data sampled at MDC rise
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            busy_r <= 1'b0;
            launched_r <= 1'b0;
            rd_op_r <= 1'b0;
            idx_r <= 6'h00;
            sh_r <= 64'h0;
            rd_r <= 16'h0000;
            mdio_out_r <= 1'b1;
            mdio_oe_n_r <= 1'b1;
        end else if (go) begin
            busy_r <= 1'b1;
            launched_r <= 1'b0;
            rd_op_r <= pwdata_in[1];
            idx_r <= 6'h00;
            sh_r <= {32'hFFFF_FFFF, 2'b00, pwdata_in[1:0], ctrl_r[8:4],
                pwdata_in[6:2], 2'b10, data_r};
        end else begin
            if (fall) begin
                if (busy_r) begin
                    mdio_out_r <= sh_r[63];
                    mdio_oe_n_r <= rd_op_r && idx_r >= 6'(HOST_TA_IDX);
                    sh_r <= {sh_r[62:0], 1'b0};
                    launched_r <= 1'b1;
                end else begin
                    mdio_out_r <= 1'b1;
                    mdio_oe_n_r <= 1'b1;
                end
            end
            if (rise && busy_r && launched_r) begin
                if (rd_op_r && idx_r >= 6'(HOST_DATA_IDX)) begin
                    rd_r <= {rd_r[14:0], in_s[1]};
                end
                idx_r <= idx_r + 6'h01;
                if (idx_r == 6'(FRAME_LAST)) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    assign link.mdc = mdc_r;
    assign link.mdio_h_out = mdio_out_r;
    assign link.mdio_h_oe_n = mdio_oe_n_r;
    assign link.txgate_oe_n = gate_oe_n_r;
    assign link.rstpin_oe_n = rst_oe_n_r;
    assign link.port_address_inputs = ctrl_r[8:4];
endmodule

/* File: trx_link_asserts.sv */
`timescale 1ns/1ps
module trx_link_asserts (
    // Clocks and reset
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic mdc,
    // Link pins
    input wire logic txgate,
    input wire logic rstpin,
    input wire logic mdio_h_oe_n,
    input wire logic mdio_d_oe_n,
    // Module status
    input wire logic laser_on_out,
    input wire logic datapath_en_out,
    input wire logic low_power_out,
    input wire logic reset_bit_out
);
    AST_PIN_SETS_BIT:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $fell(rstpin) |-> ##[0:3] reset_bit_out) else $error("reset bit not set by pin");
    AST_PIN_HOLDS:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !rstpin [*4] |-> reset_bit_out && !datapath_en_out) else $error("pin reset not held");
    AST_GATE_OFF:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $fell(txgate) |-> ##[0:3] !laser_on_out) else $error("laser late to turn off");
    AST_GATE_FORCE:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        !txgate [*4] |-> !laser_on_out) else $error("laser on with gate low");
    AST_BIT_STOPS_RUN:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $rose(reset_bit_out) |-> ##[0:1] !datapath_en_out) else $error("datapath in reset");
    AST_LOWPWR_MGMT_ONLY:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        low_power_out |-> !datapath_en_out && !laser_on_out) else $error("low power not kept");
    AST_LEAVE_LOWPWR:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $rose(txgate) && low_power_out |-> ##[1:6] !low_power_out) else $error("stuck low power");
    AST_BIT_CLEAR_RUN:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $fell(reset_bit_out) |-> ##[0:2] datapath_en_out) else $error("bit cleared, no run");
    AST_INIT_AFTER_PIN:
        assert property (@(posedge mclk_in) disable iff (!resetn_in)
        $rose(rstpin) |-> reset_bit_out [*8]) else $error("bit cleared before init");
    AST_MDIO_NO_CLASH:
        assert property (@(posedge mdc) disable iff (!resetn_in)
        !mdio_h_oe_n |-> mdio_d_oe_n) else $error("both ends drive mdio");
endmodule

/* File: transceiver_reset_lowpower_txgate_bench.sv */
`timescale 1ns/1ps
module transceiver_reset_lowpower_txgate_bench;
    import trx_pkg::*;
    logic clk = 1'b0;
    logic resetn;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, seen = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, perr, laser, dp, lp, rb;
    logic [15:0] v;
    int err_count = 0, comparisons = 0, cyc = 0, n;
    // Capability and stored supply references: address, expected
    logic [31:0] rows [5] = '{32'h8005_0001, 32'h8007_0032, 32'h8008_0032,
        32'h8009_0032, 32'h800A_04B0};
    trx_link_if lnk();
    trx_host #(.RST_MIN_CYCLES(20)) trx_host_inst (.link(lnk), .mclk_in(clk),
        .resetn_in(resetn), .paddr_in(paddr), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr));
    trx_dev #(.INIT_CYCLES(50)) trx_dev_inst (.link(lnk), .mclk_in(clk), .resetn_in(resetn),
        .laser_on_out(laser), .datapath_en_out(dp), .low_power_out(lp), .reset_bit_out(rb));
    trx_link_asserts trx_link_asserts_inst (.mclk_in(clk), .resetn_in(resetn), .mdc(lnk.mdc),
        .txgate(lnk.txgate), .rstpin(lnk.rstpin), .mdio_h_oe_n(lnk.mdio_h_oe_n),
        .mdio_d_oe_n(lnk.mdio_d_oe_n), .laser_on_out(laser), .datapath_en_out(dp),
        .low_power_out(lp), .reset_bit_out(rb));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic final_report();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rb === 1'b1) seen <= 1'b1;
        if (cyc == 60000) begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        paddr <= a;
        pwr <= w;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // One management frame, then poll until the host is idle
    task automatic mop(input logic [4:0] dv, input mdio_op_t op, input logic [15:0] x);
        apb(1'b1, HDATA_OFS, {16'h0000, x});
        apb(1'b1, HCMD_OFS, 32'h8000_0000 | {25'h0, dv, op});
        apb(1'b0, HSTAT_OFS, 32'h0);
        while (q[0] !== 1'b0) apb(1'b0, HSTAT_OFS, 32'h0);
    endtask
    task automatic mrd(input logic [4:0] dv, input logic [15:0] a);
        mop(dv, OP_ADDR, a);
        mop(dv, OP_READ, 16'h0000);
        v = q[31:16];
    endtask
    task automatic waitrun();
        for (n = 0; n < 400 && dp !== 1'b1; n++) @(negedge clk);
    endtask
    initial begin
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(negedge clk);
        chk(lp, 1);
        chk(dp, 0);
        apb(1'b0, HCTRL_OFS, 32'h0);
        chk(q, HCTRL_RST);
        apb(1'b0, HSTAT_OFS, 32'h0);
        chk(q[STAT_PRES_BIT], 1);
        apb(1'b1, HCTRL_OFS, 32'h0000_0150);
        foreach (rows[i]) begin
            mrd(DEV_PMA, rows[i][31:16]);
            chk(v, rows[i][15:0]);
        end
        chk(lp, 1);
        $display("low power start-up test done");
        apb(1'b1, HCTRL_OFS, 32'h0000_0151);
        repeat (8) @(negedge clk);
        chk(lp, 0);
        waitrun();
        chk(dp, 1);
        chk(rb, 0);
        mrd(DEV_PMA, CTRL_ADDR);
        chk(v, 0);
        mrd(DEV_PCS, CTRL_ADDR);
        chk(v, 0);
        chk(laser, 1);
        apb(1'b1, HCTRL_OFS, 32'h0000_0150);
        repeat (6) @(negedge clk);
        chk(laser, 0);
        apb(1'b1, HCTRL_OFS, 32'h0000_0151);
        repeat (8) @(negedge clk);
        chk(laser, 1);
        $display("release and gate test done");
        seen = 1'b0;
        mop(DEV_PMA, OP_ADDR, CTRL_ADDR);
        mop(DEV_PMA, OP_WRITE, 16'h8000);
        repeat (8) @(negedge clk);
        chk(seen, 1);
        do mrd(DEV_PMA, CTRL_ADDR); while (v[RESET_BIT] !== 1'b0);
        chk(dp, 1);
        $display("management reset test done");
        apb(1'b1, HCTRL_OFS, 32'h0000_0153);
        repeat (6) @(negedge clk);
        chk(rb, 1);
        chk(dp, 0);
        repeat (30) @(negedge clk);
        chk(rb, 1);
        apb(1'b1, HCTRL_OFS, 32'h0000_0151);
        waitrun();
        chk(rb, 0);
        chk(laser, 1);
        $display("pin reset test done");
        apb(1'b0, 8'h10, 32'h0);
        chk(perr, 1);
        chk(q, 0);
        $display("unmapped access test done");
        final_report();
    end
endmodule
